// ---- dmc_mode_ctrl.sv ----
// Mode control register bank behind the 4-wire serial control port
// Operation
// - Two 8-bit attenuations, default 0 dB
// - Load enable low: attenuation writes stored but not applied
// - Input format select, default 24-bit I2S
// - Format codes decoded, 110/111 reserved
// - Emphasis rate and enable, both default off
// - Stream mode: rate field selects FIR performance
// - Soft mute bit, PCM path only
// - Shared pin: stream input or zero flag
// - Bypass path monaural_en or stereo input select
// - Rolloff sharp or slow, PCM only
// - Infinite-zero mute enable, default off
// - System reset bit, default normal operation
// - One-bit stream mode enable, default off
// - Filter bypass enable, default internal filter
// - Monaural_en enable and channel select, all paths
// - Oversampling rate select, default 64 times
// - Stream mode: oversampling selects FIR rate
// - PCM zero output enable, default on
// - Two-bit stream zero output enable, default off
// - Read-only zero flags, writes ignored
// - Read-only 5-bit link identity field
// - 16-bit word: read bit, index, data
// - Write at 16th clock, read after 8th
module dmc_mode_ctrl
   import dmc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       modeSelect_n,
   input  wire logic       modeClock,
   input  wire logic       modeDataIn,
   output logic            modeDataOut,
   output logic            modeDataOutEn,
   input  wire logic       leftZeroFlag,
   input  wire logic       rightZeroFlag,
   input  wire logic [4:0] linkIdentity,
   output dmc_ctrl_t       ctrl
);

   // Pins are sampled at the core clock, so the control clock must stay well
   // below a third of it; faster host clocks lose edges.
   function automatic logic [1:0] gate2(input logic [1:0] value, input logic enable);
      gate2 = enable ? value : 2'h0;
   endfunction

   function automatic logic attenIsMute(input logic [7:0] level);
      attenIsMute = (level <= ATTEN_MUTE_MAX);
   endfunction

   logic [2:0]  pinSync;
   logic        clockPrev;
   dmc_state_t  state;
   dmc_state_t  next_state;
   logic [15:0] shiftIn;
   logic [4:0]  bitCount;
   logic        isRead;
   logic [7:0]  outShift;

   logic [7:0]  leftAtten;
   logic [7:0]  rightAtten;
   logic [7:0]  leftApplied;
   logic [7:0]  rightApplied;
   logic [7:0]  formatEmph;
   logic [7:0]  filterOut;
   logic [7:0]  pathMode;
   logic [7:0]  zeroOut;

   dmc_pin_sync
   #(
      .WIDTH       (3),
      .RESET_VALUE (3'h4)
   )
   uPinSync
   (
      .clock   (clock),
      .arst_n  (arst_n),
      .asyncIn ({modeSelect_n, modeClock, modeDataIn}),
      .syncOut (pinSync)
   );

   wire        selActive = ~pinSync[2];
   wire        clockRise = pinSync[1] & ~clockPrev;
   wire        clockFall = ~pinSync[1] & clockPrev;
   wire        takeBit   = selActive & clockRise & (state != ST_DONE);
   wire [4:0]  next_bitCount = bitCount + 5'h01;
   wire [15:0] next_shiftIn  = {shiftIn[14:0], pinSync[0]};
   wire        indexDone = takeBit & (next_bitCount == BIT_COUNT_INDEX);
   wire        wordDone  = takeBit & (next_bitCount == BIT_COUNT_WORD);

   // First eight bits: read flag then index
   wire        wordIsRead = next_shiftIn[7];
   wire [6:0]  readIndex  = next_shiftIn[6:0];
   wire [6:0]  writeIndex = next_shiftIn[IDX_MSB:IDX_LSB];
   wire [7:0]  writeData  = next_shiftIn[DATA_BITS-1:0];
   wire        writeCommit = wordDone & ~next_shiftIn[RW_BIT];

   wire        writeLeft      = writeCommit & (writeIndex == IDX_LEFT_ATTEN);
   wire        writeRight     = writeCommit & (writeIndex == IDX_RIGHT_ATTEN);
   wire        writeFormatEmph = writeCommit & (writeIndex == IDX_FORMAT_EMPH);
   wire        writeFilterOut = writeCommit & (writeIndex == IDX_FILTER_OUT);
   wire        writePathMode  = writeCommit & (writeIndex == IDX_PATH_MODE);
   wire        writeZeroOut   = writeCommit & (writeIndex == IDX_ZERO_OUT);

   wire        attenLoadEnable = formatEmph[ATTEN_LOAD_BIT];

   // Read mux; the zero flag and identity words are live, never stored
   logic [7:0] readData;
   always_comb
   begin
      readData = 8'h00;
      unique case (readIndex)
         IDX_LEFT_ATTEN  : readData = leftAtten;
         IDX_RIGHT_ATTEN : readData = rightAtten;
         IDX_FORMAT_EMPH : readData = formatEmph;
         IDX_FILTER_OUT  : readData = filterOut;
         IDX_PATH_MODE   : readData = pathMode;
         IDX_ZERO_OUT    : readData = zeroOut;
         IDX_ZERO_FLAG   : readData = {6'h00, rightZeroFlag, leftZeroFlag};
         IDX_IDENTITY    : readData = {3'h0, linkIdentity} & IDENTITY_MASK;
         default         : readData = 8'h00;
      endcase
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE  : if (selActive) next_state = ST_SHIFT;
         ST_SHIFT : if (wordDone) next_state = ST_DONE;
         ST_DONE  : next_state = ST_DONE;
         default  : next_state = ST_IDLE;
      endcase
      // Select going high always aborts, so a short word never writes
      if (!selActive)
      begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state     <= ST_IDLE;
         clockPrev <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         clockPrev <= pinSync[1];
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shiftIn  <= 16'h0000;
         bitCount <= 5'h00;
      end
      else if (!selActive)
      begin
         bitCount <= 5'h00;
      end
      else if (takeBit)
      begin
         shiftIn  <= next_shiftIn;
         bitCount <= next_bitCount;
      end
   end

   // Read data leaves MSB first, changing on falling control clock edges
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         isRead   <= 1'b0;
         outShift <= 8'h00;
      end
      else if (!selActive)
      begin
         isRead <= 1'b0;
      end
      else if (indexDone)
      begin
         isRead   <= wordIsRead;
         outShift <= readData;
      end
      else if (clockFall && isRead && bitCount >= BIT_COUNT_INDEX && bitCount < BIT_COUNT_WORD)
      begin
         outShift <= {outShift[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         modeDataOut   <= 1'b0;
         modeDataOutEn <= 1'b0;
      end
      else if (!selActive)
      begin
         modeDataOut   <= 1'b0;
         modeDataOutEn <= 1'b0;
      end
      else if (clockFall && isRead && bitCount >= BIT_COUNT_INDEX && bitCount < BIT_COUNT_WORD)
      begin
         modeDataOut   <= outShift[7];
         modeDataOutEn <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         leftAtten  <= ATTEN_RESET;
         rightAtten <= ATTEN_RESET;
      end
      else
      begin
         if (writeLeft)
         begin
            leftAtten <= writeData;
         end
         if (writeRight)
         begin
            rightAtten <= writeData;
         end
      end
   end

   // Applied levels follow a write only while loading is enabled
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         leftApplied  <= ATTEN_RESET;
         rightApplied <= ATTEN_RESET;
      end
      else
      begin
         if (writeLeft && attenLoadEnable)
         begin
            leftApplied <= writeData;
         end
         if (writeRight && attenLoadEnable)
         begin
            rightApplied <= writeData;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         formatEmph <= FORMAT_EMPH_RESET;
         filterOut <= FILTER_OUT_RESET;
         pathMode  <= PATH_MODE_RESET;
         zeroOut   <= ZERO_OUT_RESET;
      end
      else
      begin
         if (writeFormatEmph)
         begin
            formatEmph <= writeData & FORMAT_EMPH_MASK;
         end
         if (writeFilterOut)
         begin
            filterOut <= writeData & FILTER_OUT_MASK;
         end
         if (writePathMode)
         begin
            pathMode <= writeData & PATH_MODE_MASK;
         end
         if (writeZeroOut)
         begin
            zeroOut <= writeData & ZERO_OUT_MASK;
         end
      end
   end

   // Stream mode takes priority over filter bypass when both are set
   wire       streamPath = pathMode[STREAM_MODE_BIT];
   wire       bypassPath = ~streamPath & pathMode[BYPASS_EN_BIT];
   wire       pcmPath    = ~streamPath & ~pathMode[BYPASS_EN_BIT];
   wire       pcmOrBypass = pcmPath | bypassPath;

   wire [2:0] formatField     = formatEmph[FORMAT_LSB +: 3];
   wire [1:0] emphField       = formatEmph[EMPH_RATE_LSB +: 2];
   wire [1:0] oversampleField = pathMode[OVERSAMPLE_LSB +: 2];
   wire       formatBad       = (formatField > FORMAT_I2S24);

   // Reserved format codes fall back to the default so the port stays defined
   wire [2:0] formatApplied = formatBad ? FORMAT_I2S24 : formatField;

   wire [7:0] leftOut  = pcmPath ? leftApplied : ATTEN_RESET;
   wire [7:0] rightOut = pcmPath ? rightApplied : ATTEN_RESET;

   always_comb
   begin
      ctrl                        = '0;
      ctrl.leftAttenLevel         = leftOut;
      ctrl.rightAttenLevel        = rightOut;
      ctrl.leftAttenMute          = attenIsMute(leftOut);
      ctrl.rightAttenMute         = attenIsMute(rightOut);
      ctrl.inputFormatSel         = pcmOrBypass ? formatApplied : FORMAT_I2S24;
      ctrl.formatReserved         = formatBad;
      ctrl.emphasisRateSel        = gate2(emphField, pcmPath);
      ctrl.emphasisEnable         = formatEmph[EMPH_EN_BIT] & pcmPath;
      ctrl.firPerformanceSel      = gate2(emphField, streamPath);
      ctrl.softMute               = formatEmph[MUTE_BIT] & pcmPath;
      ctrl.outputPhaseInvert      = filterOut[PHASE_INV_BIT];
      ctrl.attenRampSpeed         = gate2(filterOut[RAMP_SPEED_LSB +: 2], pcmPath);
      ctrl.converterOperationCtrl = filterOut[OPERATION_BIT];
      ctrl.zeroPinFunctionSel     = filterOut[ZERO_PIN_BIT] & pcmOrBypass;
      ctrl.bypassStereoSel        = filterOut[BYPASS_STEREO_BIT] & bypassPath;
      ctrl.rolloffSel             = filterOut[ROLLOFF_BIT] & pcmPath;
      ctrl.infiniteZeroMuteEn     = filterOut[INF_ZERO_BIT] & pcmOrBypass;
      ctrl.systemResetCtrl        = pathMode[SYS_RESET_BIT];
      ctrl.oneBitStreamMode       = streamPath;
      ctrl.filterBypassEn         = pathMode[BYPASS_EN_BIT];
      ctrl.monauralEn             = pathMode[MONAURAL_BIT];
      ctrl.monoChannelSel         = pathMode[CHANNEL_SEL_BIT];
      ctrl.oversampleRateSel      = gate2(oversampleField, ~streamPath);
      ctrl.firRateSel             = gate2(oversampleField, streamPath);
      ctrl.pcmZeroOutEn           = zeroOut[PCM_ZERO_BIT] & pcmOrBypass;
      ctrl.streamZeroOutEn        = gate2(zeroOut[STREAM_ZERO_LSB +: 2], streamPath);
      ctrl.pcmPath                = pcmPath;
      ctrl.streamPath             = streamPath;
      ctrl.bypassPath             = bypassPath;
   end

endmodule

// ---- dmc_pkg.sv ----
// Shared constants, field layouts and types of the audio converter mode control bank
package dmc_pkg;

   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 8;
   localparam int IDX_BITS  = 7;

   localparam logic [4:0] BIT_COUNT_INDEX = 5'h08;
   localparam logic [4:0] BIT_COUNT_WORD  = 5'h10;

   localparam int RW_BIT  = 15;
   localparam int IDX_MSB = 14;
   localparam int IDX_LSB = 8;

   localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
   localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
   localparam logic [6:0] IDX_FORMAT_EMPH = 7'h12;
   localparam logic [6:0] IDX_FILTER_OUT  = 7'h13;
   localparam logic [6:0] IDX_PATH_MODE   = 7'h14;
   localparam logic [6:0] IDX_ZERO_OUT    = 7'h15;
   localparam logic [6:0] IDX_ZERO_FLAG   = 7'h16;
   localparam logic [6:0] IDX_IDENTITY    = 7'h17;

   localparam int ATTEN_LOAD_BIT    = 7;
   localparam int FORMAT_LSB        = 4;
   localparam int EMPH_RATE_LSB     = 2;
   localparam int EMPH_EN_BIT       = 1;
   localparam int MUTE_BIT          = 0;

   localparam int PHASE_INV_BIT     = 7;
   localparam int RAMP_SPEED_LSB    = 5;
   localparam int OPERATION_BIT     = 4;
   localparam int ZERO_PIN_BIT      = 3;
   localparam int BYPASS_STEREO_BIT = 2;
   localparam int ROLLOFF_BIT       = 1;
   localparam int INF_ZERO_BIT      = 0;

   localparam int SYS_RESET_BIT     = 6;
   localparam int STREAM_MODE_BIT   = 5;
   localparam int BYPASS_EN_BIT     = 4;
   localparam int MONAURAL_BIT      = 3;
   localparam int CHANNEL_SEL_BIT   = 2;
   localparam int OVERSAMPLE_LSB    = 0;

   localparam int STREAM_ZERO_LSB   = 1;
   localparam int PCM_ZERO_BIT      = 0;

   localparam int RIGHT_ZERO_BIT    = 1;
   localparam int LEFT_ZERO_BIT     = 0;

   localparam logic [7:0] FORMAT_EMPH_MASK = 8'hFF;
   localparam logic [7:0] FILTER_OUT_MASK = 8'hFF;
   localparam logic [7:0] PATH_MODE_MASK  = 8'h7F;
   localparam logic [7:0] ZERO_OUT_MASK   = 8'h07;
   localparam logic [7:0] IDENTITY_MASK   = 8'h1F;

   localparam logic [7:0] ATTEN_RESET      = 8'hFF;
   localparam logic [7:0] FORMAT_EMPH_RESET = 8'h50;
   localparam logic [7:0] FILTER_OUT_RESET = 8'h00;
   localparam logic [7:0] PATH_MODE_RESET  = 8'h00;
   localparam logic [7:0] ZERO_OUT_RESET   = 8'h01;

   localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;

   localparam logic [2:0] FORMAT_RJ16  = 3'h0;
   localparam logic [2:0] FORMAT_RJ20  = 3'h1;
   localparam logic [2:0] FORMAT_RJ24  = 3'h2;
   localparam logic [2:0] FORMAT_LJ24  = 3'h3;
   localparam logic [2:0] FORMAT_I2S16 = 3'h4;
   localparam logic [2:0] FORMAT_I2S24 = 3'h5;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } dmc_state_t;

   typedef struct packed
   {
      logic [7:0] leftAttenLevel;
      logic [7:0] rightAttenLevel;
      logic       leftAttenMute;
      logic       rightAttenMute;
      logic [2:0] inputFormatSel;
      logic       formatReserved;
      logic [1:0] emphasisRateSel;
      logic       emphasisEnable;
      logic [1:0] firPerformanceSel;
      logic       softMute;
      logic       outputPhaseInvert;
      logic [1:0] attenRampSpeed;
      logic       converterOperationCtrl;
      logic       zeroPinFunctionSel;
      logic       bypassStereoSel;
      logic       rolloffSel;
      logic       infiniteZeroMuteEn;
      logic       systemResetCtrl;
      logic       oneBitStreamMode;
      logic       filterBypassEn;
      logic       monauralEn;
      logic       monoChannelSel;
      logic [1:0] oversampleRateSel;
      logic [1:0] firRateSel;
      logic       pcmZeroOutEn;
      logic [1:0] streamZeroOutEn;
      logic       pcmPath;
      logic       streamPath;
      logic       bypassPath;
   } dmc_ctrl_t;

endpackage

// ---- dmc_pin_sync.sv ----
// Two-stage synchroniser for the serial control port pins
module dmc_pin_sync
#(
   parameter int         WIDTH       = 3,
   parameter logic [2:0] RESET_VALUE = 3'h0
)
(
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1  <= RESET_VALUE[WIDTH-1:0];
         syncOut <= RESET_VALUE[WIDTH-1:0];
      end
      else
      begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule

// ---- dmc_mode_ctrl_monitor.sv ----
// Port-level assertions for the mode control bank
module dmc_mode_ctrl_monitor
   import dmc_pkg::*;
(
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       modeSelect_n,
   input wire logic       modeClock,
   input wire logic       modeDataIn,
   input wire logic       modeDataOut,
   input wire logic       modeDataOutEn,
   input wire logic       leftZeroFlag,
   input wire logic       rightZeroFlag,
   input wire logic [4:0] linkIdentity,
   input wire dmc_ctrl_t  ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   chk_dout_quiet: assert property (!modeDataOutEn |-> !modeDataOut)
      else $error("read data driven while disabled");
   chk_oe_idle: assert property (modeSelect_n [*4] |-> !modeDataOutEn)
      else $error("output enable held without select");
   chk_ctrl_quiet: assert property (modeSelect_n [*4] |=> $stable(ctrl))
      else $error("controls changed with port idle");
   chk_path_onehot: assert property ($onehot({ctrl.pcmPath, ctrl.streamPath, ctrl.bypassPath}))
      else $error("path selection not one-hot");
   chk_atten_mute: assert property (ctrl.pcmPath |->
      ctrl.leftAttenMute == (ctrl.leftAttenLevel <= ATTEN_MUTE_MAX)
      && ctrl.rightAttenMute == (ctrl.rightAttenLevel <= ATTEN_MUTE_MAX))
      else $error("mute flag disagrees with level");
   chk_format_range: assert property (ctrl.inputFormatSel <= FORMAT_I2S24)
      else $error("reserved format code applied");
   chk_format_stream: assert property (ctrl.streamPath |-> ctrl.inputFormatSel == FORMAT_I2S24)
      else $error("format not parked in stream path");
   chk_stream_gate: assert property (!ctrl.streamPath |->
      {ctrl.firPerformanceSel, ctrl.firRateSel, ctrl.streamZeroOutEn} == 6'h00)
      else $error("stream controls leak outside stream path");
   chk_pcm_gate: assert property (!ctrl.pcmPath |->
      {ctrl.emphasisRateSel, ctrl.emphasisEnable, ctrl.softMute, ctrl.attenRampSpeed, ctrl.rolloffSel} == 7'h00)
      else $error("pcm controls leak outside pcm path");
   chk_bypass_gate: assert property (!ctrl.bypassPath |-> !ctrl.bypassStereoSel)
      else $error("stereo bypass select outside bypass path");
   chk_os_gate: assert property (ctrl.streamPath |-> ctrl.oversampleRateSel == 2'h0)
      else $error("oversampling select active in stream path");
endmodule

// ---- dmc_host_model.sv ----
// Host controller model that frames words on the serial control port
module dmc_host_model
(
   input  wire logic clock,
   output logic      modeSelect_n,
   output logic      modeClock,
   output logic      modeDataIn,
   input  wire logic modeDataOut,
   input  wire logic modeDataOutEn
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      modeSelect_n = 1'b1;
      modeClock = 1'b0;
      modeDataIn = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   // Fewer than 16 bits aborts the word before its latch point
   task automatic transfer(input logic [15:0] word, input int n, output logic [7:0] rd);
      rd = 8'h00;
      step(1);
      modeSelect_n = 1'b0;
      for (int i = 15; i > 15 - n; i--)
      begin
         modeDataIn = word[i];
         step(5);
         // Undriven line shows the inverse of its last level, so a missing enable is caught
         if (i < 8)
            rd[i] = modeDataOutEn ? modeDataOut : ~modeDataOut;
         step(1);
         modeClock = 1'b1;
         step(4);
         modeClock = 1'b0;
      end
      step(2);
      modeSelect_n = 1'b1;
      // A released line must not look like a held bit
      modeDataIn = ~modeDataIn;
      step(6);
   endtask
endmodule

// ---- dmc_mode_ctrl_tb_top.sv ----
// Testbench top for the mode control bank
module dmc_mode_ctrl_tb_top
   import dmc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock = 1'b0;
   logic       arst_n = 1'b0;
   logic       modeSelect_n;
   logic       modeClock;
   logic       modeDataIn;
   logic       modeDataOut;
   logic       modeDataOutEn;
   logic       leftZeroFlag = 1'b0;
   logic       rightZeroFlag = 1'b0;
   logic [4:0] linkIdentity = 5'h00;
   logic [7:0] unused;
   dmc_ctrl_t  ctrl;
   int         mismatches = 0;
   int         testsRun = 0;
   logic [6:0] rstIdx [6] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15};
   logic [7:0] rstVal [6] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01};

   always #20 clock = ~clock;

   dmc_mode_ctrl u_dmc_mode_ctrl (.clock(clock), .arst_n(arst_n), .modeSelect_n(modeSelect_n),
      .modeClock(modeClock), .modeDataIn(modeDataIn), .modeDataOut(modeDataOut),
      .modeDataOutEn(modeDataOutEn), .leftZeroFlag(leftZeroFlag), .rightZeroFlag(rightZeroFlag),
      .linkIdentity(linkIdentity), .ctrl(ctrl));

   dmc_host_model u_dmc_host_model (.clock(clock), .modeSelect_n(modeSelect_n),
      .modeClock(modeClock), .modeDataIn(modeDataIn), .modeDataOut(modeDataOut),
      .modeDataOutEn(modeDataOutEn));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expected);
      testsRun++;
      if (seen !== expected)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, expected, seen);
      end
   endtask

   task automatic regWrite(input logic [6:0] idx, input logic [7:0] data);
      u_dmc_host_model.transfer({1'b0, idx, data}, 16, unused);
   endtask

   task automatic regRead(input logic [6:0] idx, input logic [7:0] expected);
      logic [7:0] seen;
      u_dmc_host_model.transfer({1'b1, idx, 8'h00}, 16, seen);
      check($sformatf("reg %h", idx), seen, expected);
   endtask

   task automatic printVerdict();
      $display("Checks made %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clock);
      #2;
      arst_n = 1'b1;
      repeat (3) @(posedge clock);
      foreach (rstIdx[i]) regRead(rstIdx[i], rstVal[i]);
      check("left level", ctrl.leftAttenLevel, 8'hFF);
      check("format", ctrl.inputFormatSel, 8'h05);
      check("pcm zero", ctrl.pcmZeroOutEn, 8'h01);
      regWrite(IDX_LEFT_ATTEN, 8'h40);
      regRead(IDX_LEFT_ATTEN, 8'h40);
      check("left held", ctrl.leftAttenLevel, 8'hFF);
      regWrite(IDX_FORMAT_EMPH, 8'hD0);
      check("left no reload", ctrl.leftAttenLevel, 8'hFF);
      regWrite(IDX_RIGHT_ATTEN, 8'h0E);
      check("right level", ctrl.rightAttenLevel, 8'h0E);
      check("right mute", ctrl.rightAttenMute, 8'h01);
      regWrite(IDX_RIGHT_ATTEN, 8'h0F);
      check("right unmuted", ctrl.rightAttenMute, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         regWrite(IDX_FORMAT_EMPH, {1'b1, 3'(c), 4'hB});
         regRead(IDX_FORMAT_EMPH, {1'b1, 3'(c), 4'hB});
         check("format", ctrl.inputFormatSel, (c > 5) ? 8'h05 : 8'(c));
         check("format reserved", ctrl.formatReserved, 8'(c > 5));
      end
      check("emph rate", ctrl.emphasisRateSel, 8'h02);
      check("emph en", ctrl.emphasisEnable, 8'h01);
      check("soft mute", ctrl.softMute, 8'h01);
      regWrite(IDX_FILTER_OUT, 8'h6F);
      check("ramp", ctrl.attenRampSpeed, 8'h03);
      check("rolloff", ctrl.rolloffSel, 8'h01);
      check("zero pin", ctrl.zeroPinFunctionSel, 8'h01);
      check("inf zero", ctrl.infiniteZeroMuteEn, 8'h01);
      check("bypass stereo", ctrl.bypassStereoSel, 8'h00);
      regWrite(IDX_PATH_MODE, 8'hCD);
      regRead(IDX_PATH_MODE, 8'h4D);
      check("sys reset", ctrl.systemResetCtrl, 8'h01);
      check("monaural_en", {ctrl.monauralEn, ctrl.monoChannelSel}, 8'h03);
      check("os rate", ctrl.oversampleRateSel, 8'h01);
      regWrite(IDX_ZERO_OUT, 8'hFF);
      regRead(IDX_ZERO_OUT, 8'h07);
      u_dmc_host_model.transfer({1'b0, IDX_ZERO_OUT, 8'h00}, 12, unused);
      regRead(IDX_ZERO_OUT, 8'h07);
      regWrite(IDX_PATH_MODE, 8'h22);
      check("stream", ctrl.streamPath, 8'h01);
      check("stream mode", ctrl.oneBitStreamMode, 8'h01);
      check("fir rate", ctrl.firRateSel, 8'h02);
      check("fir perf", ctrl.firPerformanceSel, 8'h02);
      check("stream zero", ctrl.streamZeroOutEn, 8'h03);
      check("zero pin", ctrl.zeroPinFunctionSel, 8'h00);
      regWrite(IDX_PATH_MODE, 8'h12);
      check("bypass", ctrl.bypassPath, 8'h01);
      check("bypass en", ctrl.filterBypassEn, 8'h01);
      check("bypass stereo", ctrl.bypassStereoSel, 8'h01);
      check("os rate", ctrl.oversampleRateSel, 8'h02);
      check("format", ctrl.inputFormatSel, 8'h05);
      leftZeroFlag = 1'b1;
      regWrite(IDX_ZERO_FLAG, 8'h00);
      regRead(IDX_ZERO_FLAG, 8'h01);
      leftZeroFlag = 1'b0;
      rightZeroFlag = 1'b1;
      regRead(IDX_ZERO_FLAG, 8'h02);
      linkIdentity = 5'h15;
      regWrite(IDX_IDENTITY, 8'hFF);
      regRead(IDX_IDENTITY, 8'h15);
      regWrite(7'h20, 8'h55);
      regRead(7'h20, 8'h00);
      printVerdict();
   end
endmodule

bind dmc_mode_ctrl dmc_mode_ctrl_monitor u_dmc_mode_ctrl_monitor (.clock(clock), .arst_n(arst_n),
   .modeSelect_n(modeSelect_n), .modeClock(modeClock), .modeDataIn(modeDataIn),
   .modeDataOut(modeDataOut), .modeDataOutEn(modeDataOutEn), .leftZeroFlag(leftZeroFlag),
   .rightZeroFlag(rightZeroFlag), .linkIdentity(linkIdentity), .ctrl(ctrl));
